// ===== verilog/dac_mode_defines.svh
// Purpose: named constants for the dac mode control port
// Assumes: included by bare name; definitions only
// Notes:   offsets are register indexes carried in the control word
`ifndef DAC_MODE_DEFINES_SVH
`define DAC_MODE_DEFINES_SVH

// ------------------------------------------------------------
// control word layout
// ------------------------------------------------------------
`define WORD_BITS 16
`define WORD_COUNT_W 5
`define FRAME_LAST_COUNT 5'h10
`define IDX_MSB 14
`define IDX_LSB 8
`define DATA_MSB 7

// ------------------------------------------------------------
// register indexes
// ------------------------------------------------------------
`define IDX_LEFT_ATTEN 7'h10
`define IDX_RIGHT_ATTEN 7'h11
`define IDX_MUTE_RATE_RESET 7'h12
`define IDX_OUT_DEEMPH 7'h13
`define IDX_FORMAT_FILTER 7'h14
`define IDX_ZERO_PHASE 7'h16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_ATTEN 8'hff
`define RST_MUTE_RATE_RESET 8'h00
`define RST_OUT_DEEMPH 8'h00
`define RST_FORMAT_FILTER 8'h05
`define RST_ZERO_PHASE 8'h00
`define PINS_IDLE 8'h04

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SOFT_REINIT_BIT 7
`define OS_SELECT_BIT 6
`define RIGHT_MUTE_BIT 1
`define LEFT_MUTE_BIT 0
`define DEEMPH_RATE_MSB 6
`define DEEMPH_RATE_LSB 5
`define DEEMPH_EN_BIT 4
`define RIGHT_DISABLE_BIT 1
`define LEFT_DISABLE_BIT 0
`define ROLLOFF_BIT 5
`define FORMAT_MSB 2
`define FORMAT_LSB 0
`define COMMON_ZERO_BIT 2
`define ZERO_INVERT_BIT 1
`define PHASE_INVERT_BIT 0

// ------------------------------------------------------------
// codes and levels
// ------------------------------------------------------------
`define ATTEN_MUTE_CODE 8'h80
`define FORMAT_I2S 3'h4
`define FORMAT_RJ16 3'h3
`define DEEMPH_RATE_44K1 2'h0
`define RAMP_SAMPLE_PERIODS 8

`endif

// ===== verilog/dac_mode_pkg.sv
// Purpose: shared types of the dac mode control port
// Assumes: nothing
// Notes:   constants live in dac_mode_defines.svh
package dac_mode_pkg;

  typedef enum logic [0:0]
  {
    PORT_IDLE  = 1'b0,
    PORT_SHIFT = 1'b1
  } port_state_t;

endpackage

// ===== verilog/atten_ramp.sv
// Purpose: steps one channel's applied attenuation toward its target
// Assumes: sample_edge is a one-cycle pulse per sample period
// Notes:   codes at or below the mute code all mean full mute
`timescale 1ns/1ps
`default_nettype none
`include "dac_mode_defines.svh"

module atten_ramp
#(
  parameter int STEP_PERIODS = `RAMP_SAMPLE_PERIODS
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic restart,
  // control
  input wire logic sample_edge,
  input wire logic [7:0] target_code,
  input wire logic soft_mute,
  // state
  output logic [7:0] applied_level,
  output logic muted
);
  import dac_mode_pkg::*;

  localparam int CW = (STEP_PERIODS > 1) ? $clog2(STEP_PERIODS) : 1;

  if (STEP_PERIODS < 1)
  begin
    $error("atten_ramp: STEP_PERIODS must be at least 1");
  end

  logic [7:0] level_reg, level_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [7:0] goal;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    if (soft_mute || target_code <= `ATTEN_MUTE_CODE)
      goal = `ATTEN_MUTE_CODE;
    else
      goal = target_code;
    level_next = level_reg;
    cnt_next = cnt_reg;
    if (level_reg == goal)
      cnt_next = '0;
    else if (sample_edge)
    begin
      if (cnt_reg == CW'(STEP_PERIODS - 1))
      begin
        cnt_next = '0;
        if (level_reg < goal)
          level_next = level_reg + 8'h01;
        else
          level_next = level_reg - 8'h01;
      end
      else
        cnt_next = cnt_reg + CW'(1);
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || restart)
    begin
      level_reg <= `RST_ATTEN;
      cnt_reg <= '0;
    end
    else
    begin
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign applied_level = level_reg;
  assign muted = (level_reg <= `ATTEN_MUTE_CODE);

endmodule
`default_nettype wire

// ===== verilog/dac_mode_control_port.sv
// Purpose: three-wire mode control port and mode registers of a stereo dac
// Assumes: pins are asynchronous to ref_clk and slower than a quarter of it
// Notes:   pin_strap_mode selects strapped operation from three pins
`timescale 1ns/1ps
`default_nettype none
`include "dac_mode_defines.svh"

module dac_mode_control_port
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // serial control port
  input wire logic control_latch,
  input wire logic control_shift_clock,
  input wire logic control_serial_in,
  // strap pins
  input wire logic pin_strap_mode,
  input wire logic format_select_pin,
  input wire logic deemph_pin,
  input wire logic soft_mute_pin,
  // audio word clock, used only to time attenuation steps
  input wire logic word_clock,
  // attenuation state
  output logic [7:0] left_applied_level,
  output logic [7:0] right_applied_level,
  output logic left_muted,
  output logic right_muted,
  // mode settings
  output logic [2:0] audio_format_field,
  output logic deemph_enable,
  output logic [1:0] deemph_rate_select,
  output logic os_rate_high,
  output logic left_output_disable,
  output logic right_output_disable,
  output logic rolloff_select,
  output logic common_zero_flag_select,
  output logic zero_flag_invert,
  output logic output_phase_invert,
  // port status
  output dac_mode_pkg::port_state_t port_state,
  output logic soft_reinit
);
  import dac_mode_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // all pins retimed, no phase tie to audio
  logic [7:0] meta_reg, sync_reg, prev_reg;
  logic [7:0] pins_in;
  assign pins_in = {pin_strap_mode, format_select_pin, deemph_pin, soft_mute_pin,
                    word_clock, control_latch, control_shift_clock, control_serial_in};
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      meta_reg <= `PINS_IDLE;
      sync_reg <= `PINS_IDLE;
      prev_reg <= `PINS_IDLE;
    end
    else
    begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  logic s_strap, s_fmt, s_deemph_pin, s_mute, s_word, s_latch, s_sclk, s_sdi;
  assign {s_strap, s_fmt, s_deemph_pin, s_mute, s_word, s_latch, s_sclk, s_sdi} = sync_reg;
  logic sclk_rise, latch_fall, latch_rise, word_rise;
  assign sclk_rise = s_sclk && !prev_reg[1];
  assign latch_fall = !s_latch && prev_reg[2];
  assign latch_rise = s_latch && !prev_reg[2];
  assign word_rise = s_word && !prev_reg[3];

  // ------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------
  port_state_t state_reg, state_next;
  logic [`WORD_BITS-1:0] shift_reg, shift_next;
  logic [`WORD_COUNT_W-1:0] count_reg, count_next;
  logic commit;
  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    commit = 1'b0;
    case (state_reg)
      PORT_IDLE:
      begin
        if (latch_fall)
        begin
          state_next = PORT_SHIFT;
          count_next = '0;
        end
      end
      PORT_SHIFT:
      begin
        if (latch_rise)
        begin
          state_next = PORT_IDLE;
          // commit on latch rise; short or long frame dropped
          commit = (count_reg == `FRAME_LAST_COUNT);
        end
        else if (sclk_rise)
        begin
          // msb first into the low end
          shift_next = {shift_reg[`WORD_BITS-2:0], s_sdi};
          // count saturates past sixteen so extra clocks spoil the frame
          if (count_reg != {`WORD_COUNT_W{1'b1}})
            count_next = count_reg + `WORD_COUNT_W'(1);
        end
      end
      default:
        state_next = PORT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_reg <= PORT_IDLE;
      shift_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
    end
  end

  // index and value fields; bit 15 is not checked
  logic [6:0] register_index;
  logic [7:0] write_value;
  assign register_index = shift_reg[`IDX_MSB:`IDX_LSB];
  assign write_value = shift_reg[`DATA_MSB:0];

  // ------------------------------------------------------------
  // mode registers
  // ------------------------------------------------------------
  logic [7:0] left_atten_reg, left_atten_next;
  logic [7:0] right_atten_reg, right_atten_next;
  logic [7:0] mute_rate_reg, mute_rate_next;
  logic [7:0] out_deemph_reg, out_deemph_next;
  logic [7:0] format_filter_reg, format_filter_next;
  logic [7:0] zero_phase_reg, zero_phase_next;
  logic reinit_next;
  always_comb
  begin
    left_atten_next = left_atten_reg;
    right_atten_next = right_atten_reg;
    mute_rate_next = mute_rate_reg;
    out_deemph_next = out_deemph_reg;
    format_filter_next = format_filter_reg;
    zero_phase_next = zero_phase_reg;
    reinit_next = 1'b0;
    if (commit)
    begin
      // reserved bits stored as written, never acted on
      case (register_index)
        `IDX_LEFT_ATTEN:
          left_atten_next = write_value;
        `IDX_RIGHT_ATTEN:
          right_atten_next = write_value;
        `IDX_MUTE_RATE_RESET:
        begin
          if (write_value[`SOFT_REINIT_BIT])
          begin
            reinit_next = 1'b1;
            left_atten_next = `RST_ATTEN;
            right_atten_next = `RST_ATTEN;
            mute_rate_next = `RST_MUTE_RATE_RESET;
            out_deemph_next = `RST_OUT_DEEMPH;
            format_filter_next = `RST_FORMAT_FILTER;
            zero_phase_next = `RST_ZERO_PHASE;
          end
          else
            mute_rate_next = write_value;
        end
        `IDX_OUT_DEEMPH:
          out_deemph_next = write_value;
        `IDX_FORMAT_FILTER:
          format_filter_next = write_value;
        `IDX_ZERO_PHASE:
          zero_phase_next = write_value;
        default:
          reinit_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      left_atten_reg <= `RST_ATTEN;
      right_atten_reg <= `RST_ATTEN;
      mute_rate_reg <= `RST_MUTE_RATE_RESET;
      out_deemph_reg <= `RST_OUT_DEEMPH;
      format_filter_reg <= `RST_FORMAT_FILTER;
      zero_phase_reg <= `RST_ZERO_PHASE;
      soft_reinit <= 1'b0;
    end
    else
    begin
      left_atten_reg <= left_atten_next;
      right_atten_reg <= right_atten_next;
      mute_rate_reg <= mute_rate_next;
      out_deemph_reg <= out_deemph_next;
      format_filter_reg <= format_filter_next;
      zero_phase_reg <= zero_phase_next;
      soft_reinit <= reinit_next;
    end
  end

  // ------------------------------------------------------------
  // effective settings, strapped or programmed
  // ------------------------------------------------------------
  logic [2:0] fmt_next;
  logic deemph_pin_next, os_next, lmute_eff, rmute_eff;
  logic [1:0] rate_next;
  always_comb
  begin
    if (s_strap)
    begin
      // format pin picks i2s or 16-bit right-justified
      fmt_next = s_fmt ? `FORMAT_RJ16 : `FORMAT_I2S;
      deemph_pin_next = s_deemph_pin;
      rate_next = `DEEMPH_RATE_44K1;
      os_next = 1'b0;
      lmute_eff = s_mute;
      rmute_eff = s_mute;
    end
    else
    begin
      fmt_next = format_filter_reg[`FORMAT_MSB:`FORMAT_LSB];
      deemph_pin_next = out_deemph_reg[`DEEMPH_EN_BIT];
      rate_next = out_deemph_reg[`DEEMPH_RATE_MSB:`DEEMPH_RATE_LSB];
      os_next = mute_rate_reg[`OS_SELECT_BIT];
      lmute_eff = mute_rate_reg[`LEFT_MUTE_BIT];
      rmute_eff = mute_rate_reg[`RIGHT_MUTE_BIT];
    end
  end

  // strapped mode leaves the programmed-only controls at their defaults, except common_zero_flag_select, which it forces high
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      audio_format_field <= 3'(`RST_FORMAT_FILTER);
      deemph_enable <= 1'b0;
      deemph_rate_select <= `DEEMPH_RATE_44K1;
      os_rate_high <= 1'b0;
      left_output_disable <= 1'b0;
      right_output_disable <= 1'b0;
      rolloff_select <= 1'b0;
      common_zero_flag_select <= 1'b0;
      zero_flag_invert <= 1'b0;
      output_phase_invert <= 1'b0;
    end
    else
    begin
      audio_format_field <= fmt_next;
      deemph_enable <= deemph_pin_next;
      deemph_rate_select <= rate_next;
      os_rate_high <= os_next;
      left_output_disable <= !s_strap && out_deemph_reg[`LEFT_DISABLE_BIT];
      right_output_disable <= !s_strap && out_deemph_reg[`RIGHT_DISABLE_BIT];
      rolloff_select <= !s_strap && format_filter_reg[`ROLLOFF_BIT];
      common_zero_flag_select <= s_strap || zero_phase_reg[`COMMON_ZERO_BIT];
      zero_flag_invert <= !s_strap && zero_phase_reg[`ZERO_INVERT_BIT];
      output_phase_invert <= !s_strap && zero_phase_reg[`PHASE_INVERT_BIT];
    end
  end

  assign port_state = state_reg;

  // ------------------------------------------------------------
  // attenuation ramps
  // ------------------------------------------------------------
  // steps paced by word clock rising edges
  atten_ramp #(.STEP_PERIODS(`RAMP_SAMPLE_PERIODS)) left_ramp
  (
    .ref_clk(ref_clk), .resetn(resetn), .restart(soft_reinit), .sample_edge(word_rise),
    .target_code(s_strap ? `RST_ATTEN : left_atten_reg), .soft_mute(lmute_eff),
    .applied_level(left_applied_level), .muted(left_muted)
  );

  atten_ramp #(.STEP_PERIODS(`RAMP_SAMPLE_PERIODS)) right_ramp
  (
    .ref_clk(ref_clk), .resetn(resetn), .restart(soft_reinit), .sample_edge(word_rise),
    .target_code(s_strap ? `RST_ATTEN : right_atten_reg), .soft_mute(rmute_eff),
    .applied_level(right_applied_level), .muted(right_muted)
  );

endmodule
`default_nettype wire

// ===== tb/dac_mode_control_port_chk.sv
// Purpose: assertions on the mode control port outputs
// Assumes: bound to dac_mode_control_port
// Notes:   strap checks allow for the two-flop pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module dac_mode_control_port_chk
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // pins
  input wire logic control_latch,
  input wire logic pin_strap_mode,
  input wire logic format_select_pin,
  input wire logic deemph_pin,
  // outputs
  input wire logic [7:0] left_applied_level,
  input wire logic [7:0] right_applied_level,
  input wire logic [2:0] audio_format_field,
  input wire logic deemph_enable,
  input wire logic [1:0] deemph_rate_select,
  input wire logic os_rate_high,
  input wire logic common_zero_flag_select,
  input wire dac_mode_pkg::port_state_t port_state,
  input wire logic soft_reinit
);
  import dac_mode_pkg::*;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_reset_defaults: assert property ($rose(resetn) |->
    audio_format_field == 3'h5 && left_applied_level == 8'hff && !os_rate_high
    && !deemph_enable && port_state == PORT_IDLE) else $error("defaults wrong after reset");
  a_ramp_one_step: assert property ($changed(left_applied_level) |->
    left_applied_level - $past(left_applied_level) == 8'h01 || left_applied_level == 8'hff
    || $past(left_applied_level) - left_applied_level == 8'h01) else $error("ramp jumped");
  a_strap_format: assert property ((pin_strap_mode && $stable(format_select_pin))[*7] |->
    audio_format_field == (format_select_pin ? 3'h3 : 3'h4)) else $error("strap format wrong");
  a_strap_deemph: assert property ((pin_strap_mode && $stable(deemph_pin))[*7] |->
    deemph_enable == deemph_pin && deemph_rate_select == 2'h0) else $error("strap deemph wrong");
  a_strap_rate: assert property (pin_strap_mode[*7] |->
    !os_rate_high && common_zero_flag_select) else $error("strap rate wrong");
  a_latch_idle: assert property (control_latch[*5] |->
    port_state == PORT_IDLE) else $error("frame open with latch high");
  a_frame_open: assert property ($fell(control_latch) |->
    ##[1:5] port_state == PORT_SHIFT) else $error("frame not opened");
  a_reinit_pulse: assert property (soft_reinit |=>
    !soft_reinit) else $error("reinit pulse too long");
  a_reinit_load: assert property (soft_reinit && !pin_strap_mode |->
    ##[0:2] (audio_format_field == 3'h5 && right_applied_level == 8'hff))
    else $error("reinit did not restore defaults");
endmodule
bind dac_mode_control_port dac_mode_control_port_chk u_chk
(
  .ref_clk(ref_clk), .resetn(resetn), .control_latch(control_latch),
  .pin_strap_mode(pin_strap_mode), .format_select_pin(format_select_pin),
  .deemph_pin(deemph_pin), .left_applied_level(left_applied_level),
  .right_applied_level(right_applied_level), .audio_format_field(audio_format_field),
  .deemph_enable(deemph_enable), .deemph_rate_select(deemph_rate_select),
  .os_rate_high(os_rate_high), .common_zero_flag_select(common_zero_flag_select),
  .port_state(port_state), .soft_reinit(soft_reinit)
);
`default_nettype wire

// ===== tb/host_ctrl_model.sv
// Purpose: host side of the three-wire control port
// Assumes: caller spaces frames; pins are asynchronous to ref_clk
// Notes:   shift clock stands still and data toggles away outside frames
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model
(
  // control port lines
  output logic control_latch,
  output logic control_shift_clock,
  output logic control_serial_in
);
  initial
  begin
    control_latch = 1'b1;
    control_shift_clock = 1'b0;
    control_serial_in = 1'b0;
  end
  // one framed word, msb first, top bit zero
  task automatic send(input logic [6:0] idx, input logic [7:0] d, input int nclk);
    logic [15:0] word;
    word = {1'b0, idx, d};
    control_latch = 1'b0;
    #80;
    for (int i = 0; i < nclk; i++)
    begin
      control_serial_in = word[15 - (i % 16)];
      #40;
      control_shift_clock = 1'b1;
      #80;
      control_shift_clock = 1'b0;
      #40;
    end
    // no pull on the data line, so show something other than the last bit
    control_serial_in = ~control_serial_in;
    control_latch = 1'b1;
    #80;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the dac mode control port
// Assumes: host_ctrl_model drives the control lines
// Notes:   fast word clock keeps full ramps near eight and a half thousand cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dac_mode_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic word_clock = 1'b0;
  logic pin_strap_mode = 1'b0;
  logic format_select_pin = 1'b0;
  logic deemph_pin = 1'b0;
  logic soft_mute_pin = 1'b0;
  wire logic control_latch, control_shift_clock, control_serial_in;
  logic [7:0] left_applied_level, right_applied_level;
  logic left_muted, right_muted, deemph_enable, os_rate_high, left_output_disable;
  logic right_output_disable, rolloff_select, common_zero_flag_select, zero_flag_invert;
  logic output_phase_invert, soft_reinit;
  logic [2:0] audio_format_field;
  logic [1:0] deemph_rate_select;
  port_state_t port_state;
  int error_cnt = 0;
  int compares = 0;
  always #10 ref_clk = ~ref_clk;
  // word clock has no phase tie to the control port
  always #83 word_clock = ~word_clock;
  dac_mode_control_port u_dac_mode_control_port (.ref_clk(ref_clk), .resetn(resetn),
    .control_latch(control_latch), .control_shift_clock(control_shift_clock),
    .control_serial_in(control_serial_in), .pin_strap_mode(pin_strap_mode),
    .format_select_pin(format_select_pin), .deemph_pin(deemph_pin),
    .soft_mute_pin(soft_mute_pin), .word_clock(word_clock),
    .left_applied_level(left_applied_level), .right_applied_level(right_applied_level),
    .left_muted(left_muted), .right_muted(right_muted),
    .audio_format_field(audio_format_field), .deemph_enable(deemph_enable),
    .deemph_rate_select(deemph_rate_select), .os_rate_high(os_rate_high),
    .left_output_disable(left_output_disable), .right_output_disable(right_output_disable),
    .rolloff_select(rolloff_select), .common_zero_flag_select(common_zero_flag_select),
    .zero_flag_invert(zero_flag_invert), .output_phase_invert(output_phase_invert),
    .port_state(port_state), .soft_reinit(soft_reinit));
  host_ctrl_model u_host_ctrl_model (.control_latch(control_latch),
    .control_shift_clock(control_shift_clock), .control_serial_in(control_serial_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d, input int n = 16);
    u_host_ctrl_model.send(idx, d, n);
    cyc(8);
  endtask
  task automatic wait_level(input logic rgt, input logic [7:0] lvl, input int bound,
    output int took);
    took = 0;
    while ((rgt ? right_applied_level : left_applied_level) !== lvl && took < bound)
    begin
      cyc(1);
      took++;
    end
    if (took >= bound)
    begin
      chk(16'h0, 16'h1);
      results();
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(audio_format_field, 3'h5);
    chk({left_applied_level, right_applied_level}, 16'hffff);
    chk({os_rate_high, left_muted, right_muted, deemph_enable, deemph_rate_select}, 6'h0);
    chk({left_output_disable, right_output_disable, rolloff_select}, 3'h0);
    chk({common_zero_flag_select, zero_flag_invert, output_phase_invert, port_state}, 4'h0);
  endtask
  task automatic t_fields();
    // back to back frames, latch high only briefly between them
    u_host_ctrl_model.send(7'h16, 8'h07, 16);
    u_host_ctrl_model.send(7'h13, 8'h53, 16);
    cyc(8);
    chk({common_zero_flag_select, zero_flag_invert, output_phase_invert}, 3'h7);
    chk({deemph_rate_select, deemph_enable, left_output_disable, right_output_disable}, 5'h17);
    wr(7'h13, 8'h20);
    chk({deemph_rate_select, deemph_enable, left_output_disable, right_output_disable}, 5'h08);
    wr(7'h16, 8'h02);
    chk({common_zero_flag_select, zero_flag_invert, output_phase_invert}, 3'h2);
    wr(7'h12, 8'h40);
    chk({os_rate_high, left_muted, right_muted}, 3'h4);
    wr(7'h12, 8'h00);
    chk(os_rate_high, 1'b0);
    for (int f = 0; f < 8; f++)
    begin
      wr(7'h14, {2'h0, f[0], 2'h0, f[2:0]});
      chk({rolloff_select, audio_format_field}, {f[0], f[2:0]});
    end
  endtask
  task automatic t_refused();
    wr(7'h14, 8'h02, 15);
    chk(audio_format_field, 3'h7);
    wr(7'h14, 8'h02, 17);
    chk(audio_format_field, 3'h7);
    wr(7'h15, 8'h02);
    chk({rolloff_select, audio_format_field}, 4'hf);
    wr(7'h04, 8'h02);
    chk(audio_format_field, 3'h7);
    wr(7'h14, 8'h02);
    chk(audio_format_field, 3'h2);
  endtask
  task automatic t_ramp();
    int took;
    wr(7'h10, 8'hfd);
    wait_level(1'b0, 8'hfd, 400, took);
    chk(took > 40 && took < 140, 1'b1);
    wr(7'h12, 8'h02);
    wait_level(1'b1, 8'h80, 9500, took);
    chk({right_muted, left_muted, left_applied_level}, 10'h2fd);
    wr(7'h12, 8'h00);
    wait_level(1'b1, 8'hff, 9500, took);
    chk(right_muted, 1'b0);
    wr(7'h10, 8'h10);
    wait_level(1'b0, 8'h80, 9500, took);
    chk(left_muted, 1'b1);
    wr(7'h10, 8'h81);
    wait_level(1'b0, 8'h81, 200, took);
    chk(left_muted, 1'b0);
  endtask
  task automatic t_soft_reset();
    int n = 0;
    wr(7'h13, 8'h53);
    // the pulse is over before the frame task returns, so watch alongside it
    fork
      u_host_ctrl_model.send(7'h12, 8'h80, 16);
      begin
        while (soft_reinit !== 1'b1 && n < 200)
        begin
          cyc(1);
          n++;
        end
        chk(soft_reinit, 1'b1);
        if (n >= 200)
          results();
      end
    join
    cyc(3);
    chk({soft_reinit, audio_format_field, left_applied_level, deemph_enable}, 13'h0bfe);
    chk({left_output_disable, os_rate_high}, 2'h0);
  endtask
  task automatic t_strap();
    int took;
    pin_strap_mode = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      {format_select_pin, deemph_pin} = p[1:0];
      cyc(8);
      chk({audio_format_field, deemph_enable, deemph_rate_select, os_rate_high},
        {(p[1] ? 3'h3 : 3'h4), p[0], 3'h0});
    end
    soft_mute_pin = 1'b1;
    wait_level(1'b0, 8'h80, 9500, took);
    chk({left_muted, right_muted, right_applied_level}, 10'h380);
    soft_mute_pin = 1'b0;
    wait_level(1'b1, 8'hff, 9500, took);
    chk(left_applied_level, 8'hff);
    pin_strap_mode = 1'b0;
  endtask
  initial
  begin
    cyc(8);
    resetn = 1'b1;
    cyc(4);
    t_reset();
    t_fields();
    t_refused();
    t_ramp();
    t_soft_reset();
    t_strap();
    results();
  end
endmodule
`default_nettype wire
